/* design/ddr3_timing_power.sv */
// SDRAM command gap guard and automatic low-power control behind AHB-Lite
//
// The AHB-Lite interface to the registers and the register addresses were decided locally.
module ddr3_timing_power #(
  parameter logic [tpm_pkg::idle_w-1:0] idle_max_count = tpm_pkg::idle_full_count // Idle cap
) (
  input wire logic ref_clk, // Memory clock, drives all counts
  input wire logic rst_b, // Asynchronous reset, active low
  input wire logic clk_en, // Freezes all state but the reset synchroniser when low
  input wire logic hsel, // AHB slave select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size, words only
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic hreadyout, // AHB slave ready
  output logic [31:0] hrdata, // AHB read data
  output logic hresp, // AHB response, always OKAY
  input wire logic req_valid, // Command request, held until acknowledged
  input wire tpm_pkg::mem_cmd_type req_cmd, // Requested command
  input wire logic req_rank, // Requested chip select
  output logic req_ack, // Request issued, one cycle
  output logic mem_cmd_valid, // Command on the SDRAM bus, one cycle
  output tpm_pkg::mem_cmd_type mem_cmd, // Command code
  output logic mem_rank, // Chip select of the command
  output logic sdram_clock_enable_pin // SDRAM clock enable
);
  import tpm_pkg::*;

  logic rst_meta_q;
  logic rst_n_s;
  logic [31:0] timing_two_q;
  logic [31:0] timing_three_q;
  logic [31:0] timing_four_q;
  logic [31:0] power_ctl_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] rd_word;
  logic [gap_w-1:0] tload [num_timers];
  logic [num_timers-1:0] tstart;
  logic [num_timers-1:0] tdone;
  power_state_type state_q;
  logic last_rd_q;
  logic last_rank_q;
  logic cmd_ok;
  logic rank_ok;
  logic quiet;
  logic go_issue;
  logic go_pd;
  logic go_sr;
  logic go_pdx;
  logic go_srx;
  logic idle_exp;
  logic [lp_w-1:0] lp_sel;
  logic addr_acc;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q <= 1'b0;
      rst_n_s <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_s <= rst_meta_q;
    end
  end

  // AHB address phase taken only when the previous transfer is done
  assign addr_acc = hsel & htrans[1] & hready;

  // Read mux; reserved bits already held at zero
  always_comb begin
    unique case (haddr[7:0])
      off_timing_two: rd_word = timing_two_q;
      off_timing_three: rd_word = timing_three_q;
      off_timing_four: rd_word = timing_four_q;
      off_power_ctl: rd_word = power_ctl_q;
      off_status: rd_word = {16'h0000, tdone, state_q, sdram_clock_enable_pin};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Zero-wait slave: ready from the first enabled clock out of reset, always OKAY
  always_ff @(posedge ref_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else if (clk_en) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_q <= addr_acc & hwrite;
      if (addr_acc) begin
        wr_addr_q <= haddr[7:0];
      end
      if (addr_acc & !hwrite) begin
        hrdata <= rd_word;
      end
    end
  end

  // Write in the data phase; masks drop reserved bits
  always_ff @(posedge ref_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      timing_two_q <= rst_timing_two;
      timing_three_q <= rst_timing_three;
      timing_four_q <= rst_timing_four;
      power_ctl_q <= rst_power_ctl;
    end else if (clk_en && wr_pend_q) begin
      unique case (wr_addr_q)
        off_timing_two: timing_two_q <= hwdata & msk_timing_two;
        off_timing_three: timing_three_q <= hwdata & msk_timing_three;
        off_timing_four: timing_four_q <= hwdata & msk_timing_four;
        off_power_ctl: power_ctl_q <= hwdata & msk_power_ctl;
        default: ;
      endcase
    end
  end

  // Gap lengths straight from the timing fields
  assign tload[read_write_turnaround] = gap_w'(timing_two_q[rtw_lsb +: rtw_w]);
  assign tload[t_rp] = gap_w'(timing_two_q[rp_lsb +: rp_w]);
  assign tload[activate_to_access_delay] = gap_w'(timing_two_q[rcd_lsb +: rcd_w]);
  assign tload[t_xp] = gap_w'(timing_three_q[xp_lsb +: xp_w]);
  assign tload[selfrefresh_exit_nodll_delay] = timing_three_q[xsnr_lsb +: xsnr_w];
  assign tload[selfrefresh_exit_dll_delay] = timing_three_q[xsrd_lsb +: xsrd_w];
  assign tload[read_to_precharge_delay] = gap_w'(timing_three_q[rtp_lsb +: rtp_w]);
  assign tload[t_cke] = gap_w'(timing_three_q[ckemin_lsb +: ckemin_w]);
  assign tload[t_rank] = gap_w'(timing_four_q[rank_lsb +: rank_w]);
  assign tload[selfrefresh_min_residency] = gap_w'(timing_four_q[ckesr_lsb +: ckesr_w]);
  assign tload[t_zq] = gap_w'(timing_four_q[zq_lsb +: zq_w]);
  assign tload[refresh_cycle_time] = timing_four_q[rfc_lsb +: rfc_w];
  assign lp_sel = power_ctl_q[lp_lsb +: lp_w];

  // One gap timer per constraint
  for (genvar i = 0; i < num_timers; i++) begin : g_gap
    gap_timer #(.width(gap_w)) u_gap (
      .clk(ref_clk),
      .rst_n(rst_n_s),
      .ce(clk_en),
      .start(tstart[i]),
      .load(tload[i]),
      .done(tdone[i])
    );
  end

  // Rank switch matters only between data phases of the same kind
  assign rank_ok = tdone[t_rank] | (last_rank_q == req_rank) |
    (last_rd_q != (req_cmd == c_rd));

  // Command legality against the gaps that guard each command
  always_comb begin
    unique case (req_cmd)
      c_act: cmd_ok = tdone[t_rp] & tdone[refresh_cycle_time] & tdone[t_xp] &
        tdone[selfrefresh_exit_nodll_delay] & tdone[t_zq];
      c_rd: cmd_ok = tdone[activate_to_access_delay] & rank_ok & tdone[selfrefresh_exit_dll_delay] &
        tdone[selfrefresh_exit_nodll_delay] & tdone[t_zq];
      c_wr: cmd_ok = tdone[activate_to_access_delay] & rank_ok & tdone[selfrefresh_exit_dll_delay] & tdone[selfrefresh_exit_nodll_delay] &
        tdone[t_xp] & tdone[t_zq] & (tdone[read_write_turnaround] | !last_rd_q);
      c_pre: cmd_ok = tdone[read_to_precharge_delay] & tdone[t_xp] & tdone[selfrefresh_exit_nodll_delay] &
        tdone[t_zq];
      c_ref, c_lmr: cmd_ok = tdone[t_rp] & tdone[refresh_cycle_time] & tdone[t_xp] &
        tdone[selfrefresh_exit_nodll_delay] & tdone[t_zq];
      c_zqcs: cmd_ok = tdone[t_xp] & tdone[selfrefresh_exit_nodll_delay] & tdone[t_zq];
      default: cmd_ok = 1'b0;
    endcase
  end

  // Low-power entry waits for the bus to settle and the pin gap
  assign quiet = !req_valid & !req_ack & idle_exp & tdone[t_cke] &
    tdone[t_rp] & tdone[refresh_cycle_time] & tdone[t_zq];
  assign go_issue = (state_q == st_active) & req_valid & !req_ack & cmd_ok;
  assign go_pd = (state_q == st_active) & quiet & (lp_sel == lp_powerdown);
  assign go_sr = (state_q == st_active) & quiet & (lp_sel == lp_selfrefresh);
  assign go_pdx = (state_q == st_pd) & req_valid & tdone[t_cke];
  assign go_srx = (state_q == st_sr) & req_valid & tdone[t_cke] & tdone[selfrefresh_min_residency];

  // Timer starts from the events they guard
  always_comb begin
    tstart = '0;
    tstart[read_write_turnaround] = go_issue & (req_cmd == c_rd);
    tstart[t_rp] = go_issue & (req_cmd == c_pre);
    tstart[activate_to_access_delay] = go_issue & (req_cmd == c_act);
    tstart[t_xp] = go_pdx;
    tstart[selfrefresh_exit_nodll_delay] = go_srx;
    tstart[selfrefresh_exit_dll_delay] = go_srx;
    tstart[read_to_precharge_delay] = go_issue & (req_cmd == c_rd);
    tstart[t_cke] = go_pd | go_sr | go_pdx | go_srx;
    tstart[t_rank] = go_issue & ((req_cmd == c_rd) | (req_cmd == c_wr));
    tstart[selfrefresh_min_residency] = go_sr;
    tstart[t_zq] = go_issue & (req_cmd == c_zqcs);
    tstart[refresh_cycle_time] = go_issue & ((req_cmd == c_ref) | (req_cmd == c_lmr));
  end

  // Idle time runs from the timer field of the selected mode
  idle_timer #(.max_count(idle_max_count)) u_idle (
    .clk(ref_clk),
    .rst_n(rst_n_s),
    .ce(clk_en),
    .restart(req_valid | req_ack | (state_q != st_active)),
    .code((lp_sel == lp_powerdown) ? power_ctl_q[powerdown_idle_timer_lsb +: idle_code_w] :
      power_ctl_q[selfrefresh_idle_timer_lsb +: idle_code_w]),
    .expired(idle_exp)
  );

  // Power state and the clock-enable pin
  always_ff @(posedge ref_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      state_q <= st_active;
      sdram_clock_enable_pin <= 1'b1;
    end else if (clk_en) begin
      unique case (state_q)
        st_active: begin
          if (go_pd) begin
            state_q <= st_pd;
            sdram_clock_enable_pin <= 1'b0;
          end else if (go_sr) begin
            state_q <= st_sr;
            sdram_clock_enable_pin <= 1'b0;
          end
        end
        st_pd: begin
          if (go_pdx) begin
            state_q <= st_active;
            sdram_clock_enable_pin <= 1'b1;
          end
        end
        st_sr: begin
          if (go_srx) begin
            state_q <= st_active;
            sdram_clock_enable_pin <= 1'b1;
          end
        end
        default: begin
          state_q <= st_active;
          sdram_clock_enable_pin <= 1'b1;
        end
      endcase
    end
  end

  // Command outputs; self-refresh entry shares the command port
  always_ff @(posedge ref_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      mem_cmd_valid <= 1'b0;
      mem_cmd <= c_act;
      mem_rank <= 1'b0;
      req_ack <= 1'b0;
    end else if (clk_en) begin
      mem_cmd_valid <= go_issue | go_sr;
      req_ack <= go_issue;
      if (go_issue) begin
        mem_cmd <= req_cmd;
        mem_rank <= req_rank;
      end else if (go_sr) begin
        mem_cmd <= c_sre;
      end
    end
  end

  // Kind and rank of the last data phase
  always_ff @(posedge ref_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      last_rd_q <= 1'b0;
      last_rank_q <= 1'b0;
    end else if (clk_en && go_issue && ((req_cmd == c_rd) || (req_cmd == c_wr))) begin
      last_rd_q <= (req_cmd == c_rd);
      last_rank_q <= req_rank;
    end
  end

  // Checking helpers: cycles since each visible event, saturating
  localparam int since_w = 11;
  localparam int n_ev = 9;
  localparam int e_act = 0;
  localparam int e_pre = 1;
  localparam int e_rd = 2;
  localparam int e_wr = 3;
  localparam int e_rfl = 4;
  localparam int e_zq = 5;
  localparam int e_cke = 6;
  localparam int e_pdx = 7;
  localparam int e_srx = 8;
  logic [since_w-1:0] since_q [n_ev];
  logic [n_ev-1:0] ev;
  logic cke_seen_q;
  power_state_type state_seen_q;
  logic vis;

  assign vis = mem_cmd_valid;
  assign ev[e_act] = vis & (mem_cmd == c_act);
  assign ev[e_pre] = vis & (mem_cmd == c_pre);
  assign ev[e_rd] = vis & (mem_cmd == c_rd);
  assign ev[e_wr] = vis & (mem_cmd == c_wr);
  assign ev[e_rfl] = vis & ((mem_cmd == c_ref) | (mem_cmd == c_lmr));
  assign ev[e_zq] = vis & (mem_cmd == c_zqcs);
  assign ev[e_cke] = sdram_clock_enable_pin != cke_seen_q;
  assign ev[e_pdx] = ev[e_cke] & (state_seen_q == st_pd);
  assign ev[e_srx] = ev[e_cke] & (state_seen_q == st_sr);

  always_ff @(posedge ref_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      cke_seen_q <= 1'b1;
      state_seen_q <= st_active;
      for (int i = 0; i < n_ev; i++) since_q[i] <= '1;
    end else if (clk_en) begin
      cke_seen_q <= sdram_clock_enable_pin;
      state_seen_q <= state_q;
      for (int i = 0; i < n_ev; i++) begin
        if (ev[i]) since_q[i] <= '0;
        else if (since_q[i] != '1) since_q[i] <= since_q[i] + 1'b1;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n_s);

  property p_rtw;
    clk_en && ev[e_wr] && since_q[e_rd] < since_q[e_wr] |->
      since_q[e_rd] >= since_w'(tload[read_write_turnaround]);
  endproperty
  a_rtw: assert property (p_rtw) else $error("write too soon after read");

  property p_rp;
    clk_en && (ev[e_act] || ev[e_rfl]) |-> since_q[e_pre] >= since_w'(tload[t_rp]);
  endproperty
  a_rp: assert property (p_rp) else $error("precharge gap short");

  property p_rcd;
    clk_en && (ev[e_rd] || ev[e_wr]) |-> since_q[e_act] >= since_w'(tload[activate_to_access_delay]);
  endproperty
  a_rcd: assert property (p_rcd) else $error("activate gap short");

  property p_xp;
    clk_en && vis && mem_cmd != c_rd |-> since_q[e_pdx] >= since_w'(tload[t_xp]);
  endproperty
  a_xp: assert property (p_xp) else $error("power-down exit gap short");

  property p_xsnr;
    clk_en && vis |-> since_q[e_srx] >= since_w'(tload[selfrefresh_exit_nodll_delay]);
  endproperty
  a_xsnr: assert property (p_xsnr) else $error("self-refresh exit gap short");

  property p_xsrd;
    clk_en && (ev[e_rd] || ev[e_wr]) |-> since_q[e_srx] >= since_w'(tload[selfrefresh_exit_dll_delay]);
  endproperty
  a_xsrd: assert property (p_xsrd) else $error("DLL relock gap short");

  property p_rtp;
    clk_en && ev[e_pre] |-> since_q[e_rd] >= since_w'(tload[read_to_precharge_delay]);
  endproperty
  a_rtp: assert property (p_rtp) else $error("read to precharge gap short");

  property p_cke;
    clk_en && ev[e_cke] |-> since_q[e_cke] >= since_w'(tload[t_cke]);
  endproperty
  a_cke: assert property (p_cke) else $error("clock enable toggled too fast");

  property p_ckesr;
    clk_en && ev[e_srx] |-> since_q[e_cke] >= since_w'(tload[selfrefresh_min_residency]);
  endproperty
  a_ckesr: assert property (p_ckesr) else $error("self-refresh too short");

  property p_zq;
    clk_en && vis |-> since_q[e_zq] >= since_w'(tload[t_zq]);
  endproperty
  a_zq: assert property (p_zq) else $error("calibration gap short");

  property p_rfc;
    clk_en && (ev[e_act] || ev[e_rfl]) |-> since_q[e_rfl] >= since_w'(tload[refresh_cycle_time]);
  endproperty
  a_rfc: assert property (p_rfc) else $error("refresh cycle gap short");

  sequence s_enter;
    state_seen_q == st_active ##0 state_q != st_active;
  endsequence
  property p_mode;
    s_enter |-> (state_q == st_pd) == ($past(lp_sel) == lp_powerdown);
  endproperty
  a_mode: assert property (p_mode) else $error("wrong low-power mode entered");

  sequence s_asleep_req;
    clk_en && state_q != st_active && req_valid;
  endsequence
  property p_wake;
    s_asleep_req |-> ##[1:20] (state_q == st_active && sdram_clock_enable_pin);
  endproperty
  a_wake: assert property (p_wake) else $error("request did not wake memory");
endmodule

/* design/tpm_pkg.sv */
// Constants and types shared by the SDRAM timing and low-power block
package tpm_pkg;
  // Register byte offsets
  localparam logic [7:0] off_timing_two = 8'h00;
  localparam logic [7:0] off_timing_three = 8'h04;
  localparam logic [7:0] off_timing_four = 8'h08;
  localparam logic [7:0] off_power_ctl = 8'h0c;
  localparam logic [7:0] off_status = 8'h10;
  // Reset values
  localparam logic [31:0] rst_timing_two = 32'h0000_0000;
  localparam logic [31:0] rst_timing_three = 32'hffff_ffff;
  localparam logic [31:0] rst_timing_four = 32'hffff_3fff;
  localparam logic [31:0] rst_power_ctl = 32'h0000_0000;
  // Writable bits; the rest are reserved
  localparam logic [31:0] msk_timing_two = 32'h0000_1fff;
  localparam logic [31:0] msk_timing_three = 32'hffff_ffff;
  localparam logic [31:0] msk_timing_four = 32'hffff_3fff;
  localparam logic [31:0] msk_power_ctl = 32'h0000_f7f0;
  // Field positions and widths
  localparam int rtw_lsb = 10;
  localparam int rtw_w = 3;
  localparam int rp_lsb = 5;
  localparam int rp_w = 5;
  localparam int rcd_lsb = 0;
  localparam int rcd_w = 5;
  localparam int xp_lsb = 28;
  localparam int xp_w = 4;
  localparam int xsnr_lsb = 18;
  localparam int xsnr_w = 10;
  localparam int xsrd_lsb = 8;
  localparam int xsrd_w = 10;
  localparam int rtp_lsb = 4;
  localparam int rtp_w = 4;
  localparam int ckemin_lsb = 0;
  localparam int ckemin_w = 4;
  localparam int rank_lsb = 28;
  localparam int rank_w = 4;
  localparam int ckesr_lsb = 24;
  localparam int ckesr_w = 4;
  localparam int zq_lsb = 16;
  localparam int zq_w = 8;
  localparam int rfc_lsb = 4;
  localparam int rfc_w = 10;
  localparam int powerdown_idle_timer_lsb = 12;
  localparam int selfrefresh_idle_timer_lsb = 4;
  localparam int idle_code_w = 4;
  localparam int lp_lsb = 8;
  localparam int lp_w = 3;
  localparam logic [2:0] lp_selfrefresh = 3'h2;
  localparam logic [2:0] lp_powerdown = 3'h4;
  // Gap timers, one per constraint
  localparam int gap_w = 10;
  localparam int num_timers = 12;
  localparam int read_write_turnaround = 0;
  localparam int t_rp = 1;
  localparam int activate_to_access_delay = 2;
  localparam int t_xp = 3;
  localparam int selfrefresh_exit_nodll_delay = 4;
  localparam int selfrefresh_exit_dll_delay = 5;
  localparam int read_to_precharge_delay = 6;
  localparam int t_cke = 7;
  localparam int t_rank = 8;
  localparam int selfrefresh_min_residency = 9;
  localparam int t_zq = 10;
  localparam int refresh_cycle_time = 11;
  // Idle ladder: 2^(code+3) clocks, code 0 is zero clocks, code 10 is an odd entry
  localparam int idle_w = 19;
  localparam logic [4:0] idle_base_shift = 5'h03;
  localparam logic [3:0] idle_odd_code = 4'ha;
  localparam logic [18:0] idle_odd_count = 19'h022d0;
  localparam logic [18:0] idle_full_count = 19'h40000;
  typedef enum logic [2:0] {
    st_active = 3'b001,
    st_pd = 3'b010,
    st_sr = 3'b100
  } power_state_type;
  typedef enum logic [2:0] {
    c_act = 3'h0,
    c_rd = 3'h1,
    c_wr = 3'h2,
    c_pre = 3'h3,
    c_ref = 3'h4,
    c_lmr = 3'h5,
    c_zqcs = 3'h6,
    c_sre = 3'h7
  } mem_cmd_type;
endpackage

/* design/gap_timer.sv */
// Down-counter that reports when a minimum command gap has elapsed
module gap_timer #(
  parameter int width = 10 // Counter width
) (
  input wire logic clk, // Memory clock
  input wire logic rst_n, // Synchronised reset, active low
  input wire logic ce, // Clock enable
  input wire logic start, // Load the gap value
  input wire logic [width-1:0] load, // Gap minus one
  output logic done // Gap has elapsed
);
  logic [width-1:0] cnt_q;

  // Load on start, then count down to zero and rest there
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (start) begin
        cnt_q <= load;
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  assign done = (cnt_q == '0);
endmodule

/* design/idle_timer.sv */
// Idle counter against the power-of-two ladder of the low-power timers
module idle_timer #(
  parameter logic [tpm_pkg::idle_w-1:0] max_count = tpm_pkg::idle_full_count // Ladder cap
) (
  input wire logic clk, // Memory clock
  input wire logic rst_n, // Synchronised reset, active low
  input wire logic ce, // Clock enable
  input wire logic restart, // Activity seen, start over
  input wire logic [tpm_pkg::idle_code_w-1:0] code, // Ladder code
  output logic expired // Idle long enough
);
  import tpm_pkg::*;
  logic [idle_w-1:0] cnt_q;
  logic [idle_w-1:0] thr;

  // Threshold from the code; the cap only exists to shorten simulation
  always_comb begin
    if (code == '0) begin
      thr = '0;
    end else if (code == idle_odd_code) begin
      thr = idle_odd_count;
    end else begin
      thr = idle_w'(1) << ({1'b0, code} + idle_base_shift);
    end
    if (thr > max_count) begin
      thr = max_count;
    end
  end

  // Saturates at the threshold so it never wraps back to busy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (restart) begin
        cnt_q <= '0;
      end else if (cnt_q < thr) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  assign expired = (cnt_q >= thr);
endmodule

/* sim/sdram_model.sv */
// Far-side SDRAM stand-in that times commands and clock-enable levels
module sdram_model (
  input wire logic ref_clk, // Memory clock
  input wire logic cmd_valid, // Command strobe
  input wire logic cke, // Clock-enable pin
  output int gap, // Cycles between last two commands
  output int since_cmd, // Cycles since last command
  output int since_cke, // Cycles since last enable edge
  output int cke_hold // Length of level before that edge
);
  timeunit 1ns;
  timeprecision 1ps;
  bit cke_q;
  // Running counts, cleared by the event they time from
  always @(posedge ref_clk) begin
    since_cmd <= since_cmd + 1;
    since_cke <= since_cke + 1;
    cke_q <= cke;
    if (cmd_valid === 1'b1) begin
      gap <= since_cmd + 1;
      since_cmd <= 0;
    end
    if (cke !== cke_q) begin
      cke_hold <= since_cke + 1;
      since_cke <= 0;
    end
  end
endmodule

/* sim/test_ddr3_timing_power.sv */
// Self-checking bench for the command gap guard and low-power control
module test_ddr3_timing_power;
  import tpm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, rst_b = 0, hsel = 0, hwrite = 0, req_valid = 0, req_rank = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, req_ack, mem_cmd_valid, mem_rank, cke;
  mem_cmd_type req_cmd = c_act, mem_cmd;
  int gap, since_cmd, since_cke, cke_hold, err_total = 0, check_count = 0, cyc = 0;
  ddr3_timing_power #(.idle_max_count(19'h00040)) dut (.ref_clk(ref_clk), .rst_b(rst_b),
    .clk_en(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .req_valid(req_valid), .req_cmd(req_cmd),
    .req_rank(req_rank), .req_ack(req_ack), .mem_cmd_valid(mem_cmd_valid),
    .mem_cmd(mem_cmd), .mem_rank(mem_rank), .sdram_clock_enable_pin(cke));
  sdram_model mem (.ref_clk(ref_clk), .cmd_valid(mem_cmd_valid), .cke(cke), .gap(gap),
    .since_cmd(since_cmd), .since_cke(since_cke), .cke_hold(cke_hold));
  // 125 MHz memory clock
  always #4 ref_clk = ~ref_clk;
  // Watchdog so a missing ack cannot hang the run
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (err_total == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic ge(input int got, input int least);
    check_count++;
    if (got < least) begin
      err_total++;
      $display("FAIL %0t span %0d below %0d", $time, got, least);
    end
  endtask
  // Single AHB-Lite transfer; read data taken at the end of the data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Request held until ack; one idle edge keeps requests three cycles apart
  task automatic issue(input mem_cmd_type c, input logic r);
    req_valid <= 1'b1;
    req_cmd <= c;
    req_rank <= r;
    do @(posedge ref_clk); while (req_ack !== 1'b1);
    req_valid <= 1'b0;
    @(posedge ref_clk);
  endtask
  // Reset values, reserved bits and an unmapped word
  task automatic regs();
    logic [7:0] a[5] = '{off_timing_two, off_timing_three, off_timing_four, off_power_ctl,
      8'h14};
    logic [31:0] r[5] = '{rst_timing_two, rst_timing_three, rst_timing_four, rst_power_ctl,
      32'h0};
    logic [31:0] m[5] = '{msk_timing_two, msk_timing_three, msk_timing_four, msk_power_ctl,
      32'h0};
    logic [31:0] d;
    for (int i = 0; i < 5; i++) begin
      ahb(1'b0, a[i], 32'h0, d);
      cmp(d, r[i]);
      cmp({31'h0, hresp}, 32'h0);
      ahb(1'b1, a[i], 32'hffff_ffff, d);
      ahb(1'b0, a[i], 32'h0, d);
      cmp(d, m[i]);
    end
  endtask
  // Back-to-back commands against programmed gaps
  task automatic gaps();
    mem_cmd_type c[12] = '{c_ref, c_act, c_rd, c_wr, c_rd, c_rd, c_pre, c_act, c_zqcs, c_act,
      c_lmr, c_ref};
    int g[12] = '{0, 16, 10, 4, 0, 5, 6, 7, 0, 11, 0, 16};
    logic [11:0] rk = 12'h0e0;
    logic [31:0] d;
    ahb(1'b1, off_timing_two, 32'h0000_0cc9, d);
    ahb(1'b1, off_timing_three, 32'h2030_1453, d);
    ahb(1'b1, off_timing_four, 32'h460a_00ff, d);
    for (int i = 0; i < 12; i++) begin
      issue(c[i], rk[i]);
      ge(gap, g[i]);
      cmp({29'h0, mem_cmd}, {29'h0, c[i]});
      cmp({31'h0, mem_rank}, {31'h0, rk[i]});
    end
  endtask
  // Idle entry, minimum low time, then wake by request and exit gap
  task automatic lowp(input logic [31:0] pm, input mem_cmd_type wc, input int idle_min,
    input int low_min, input int exit_min, input logic sr);
    int n;
    logic [31:0] d;
    ahb(1'b1, off_power_ctl, pm, d);
    issue(c_wr, 1'b0);
    n = 0;
    while (cke !== 1'b0) begin
      @(posedge ref_clk);
      n++;
    end
    ge(n, idle_min);
    @(posedge ref_clk);
    if (sr) cmp({29'h0, mem_cmd}, {29'h0, c_sre});
    issue(wc, 1'b0);
    ge(cke_hold, low_min);
    ge(since_cke, exit_min);
  endtask
  // Main sequence
  initial begin
    logic [31:0] d;
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    regs();
    gaps();
    lowp(32'h0000_1400, c_act, 15, 4, 3, 1'b0);
    lowp(32'h0000_0200, c_rd, 0, 7, 21, 1'b1);
    lowp(32'h0000_0200, c_act, 0, 7, 13, 1'b1);
    ahb(1'b1, off_power_ctl, 32'h0000_0100, d);
    issue(c_wr, 1'b0);
    repeat (100) @(posedge ref_clk);
    cmp({31'h0, cke}, 32'h1);
    ahb(1'b0, off_status, 32'h0, d);
    cmp(d, 32'h0000_fff3);
    wrap_up();
  end
endmodule
